// File: include/sfp_pkg.sv
// Constants, field layouts and carrier types for the softener status frame packer.
package sfp_pkg;

    localparam int unsigned IMG_BYTES   = 62;
    localparam int unsigned IMG_AW      = 6;
    localparam int unsigned WB_AW       = 8;

    // Register byte addresses on the bus.
    localparam logic [7:0] ADR_FAULT    = 8'h00;
    localparam logic [7:0] ADR_STATE    = 8'h04;
    localparam logic [7:0] ADR_HOURS    = 8'h08;
    localparam logic [7:0] ADR_DAYS     = 8'h0c;
    localparam logic [7:0] ADR_CAP      = 8'h10;
    localparam logic [7:0] ADR_FLOW1    = 8'h14;
    localparam logic [7:0] ADR_FLOW2    = 8'h18;
    localparam logic [7:0] ADR_FLOW3    = 8'h1c;
    localparam logic [7:0] ADR_BLEND    = 8'h20;
    localparam logic [7:0] ADR_REGCNT   = 8'h24;
    localparam logic [7:0] ADR_VOLUME   = 8'h28;
    localparam logic [7:0] ADR_LINK     = 8'h2c;
    localparam logic [7:0] ADR_CMD      = 8'h30;

    // Fault register fields.
    localparam int unsigned F_ZERO      = 0;
    localparam int unsigned F_HIGH      = 1;
    localparam int unsigned F_LOW       = 2;
    localparam int unsigned F_FLOW1     = 3;
    localparam int unsigned F_FLOW2     = 4;
    localparam int unsigned F_FLOW3     = 5;
    localparam int unsigned F_NINE      = 6;
    localparam int unsigned F_MAINT     = 7;
    localparam int unsigned F_ONE       = 8;
    localparam int unsigned F_TWO       = 9;
    localparam int unsigned F_THREE     = 10;
    localparam int unsigned F_SIX_SEVEN = 11;
    localparam int unsigned F_B1_2      = 12;
    localparam int unsigned F_CELL_C    = 13;
    localparam int unsigned F_CELL_D    = 14;

    // State register fields.
    localparam int unsigned S_REGEN     = 3;
    localparam int unsigned S_STEP_LSB  = 8;

    // Command status register fields.
    localparam int unsigned C_LOCK      = 0;
    localparam int unsigned C_PENDING   = 1;
    localparam int unsigned C_MANUAL    = 2;
    localparam int unsigned C_ADDR_LSB  = 8;
    localparam int unsigned C_ADDR_OK   = 16;

    // Command byte bits from the master.
    localparam int unsigned CMD_MANUAL  = 0;
    localparam int unsigned CMD_LOCK    = 1;

    // Image byte positions.
    localparam logic [5:0] IDX_HOURS    = 6'h04;
    localparam logic [5:0] IDX_DAYS     = 6'h06;
    localparam logic [5:0] IDX_CAP      = 6'h08;
    localparam logic [5:0] IDX_FLOW1    = 6'h0b;
    localparam logic [5:0] IDX_REGCNT   = 6'h1b;
    localparam logic [5:0] IDX_VOLUME   = 6'h1f;
    localparam logic [5:0] IDX_FREE     = 6'h23;
    localparam logic [5:0] IDX_LINK     = 6'h3d;
    localparam int unsigned B_LINK_OK   = 7;

    localparam logic [7:0] ADDR_MIN     = 8'h01;
    localparam logic [7:0] ADDR_MAX     = 8'hfe;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sfp_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } sfp_wb_rsp_t;

    typedef struct packed {
        logic        start;
        logic        lock;
        logic        pending;
    } sfp_cmd_t;

endpackage

// File: logic/sfp_cmd_decode.sv
// Command byte decoder: manual regeneration on toggle and held regeneration lock.
`timescale 1ns/100ps
module sfp_cmd_decode
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [7:0]       cmd_byte,
    input  wire logic             clear_pending,
    output sfp_pkg::sfp_cmd_t     cmd
);

    typedef struct packed {
        logic prev;
        logic primed;
        logic lock;
        logic start;
        logic pending;
    } sfp_cmd_state_t;

    sfp_cmd_state_t q;
    sfp_cmd_state_t next_q;

    ////////////////////////////////////////////////////////////////////////
    // The first sample after reset only primes the edge detector, so a bit
    // that is already set at power up does not start a regeneration.
    always_comb
    begin
        next_q         = q;
        next_q.prev    = cmd_byte[sfp_pkg::CMD_MANUAL];
        next_q.primed  = 1'b1;
        next_q.start   = q.primed && (cmd_byte[sfp_pkg::CMD_MANUAL] != q.prev);
        next_q.lock    = cmd_byte[sfp_pkg::CMD_LOCK];
        next_q.pending = next_q.start || (q.pending && !clear_pending);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign cmd = '{start: q.start, lock: q.lock, pending: q.pending};

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence manual_toggle;
        q.primed ##1 $changed(cmd_byte[sfp_pkg::CMD_MANUAL]);
    endsequence

    lock_follows_a: assert property ($past(cmd_byte[1]) == cmd.lock)
        else $error("lock does not follow the held command bit");
    toggle_start_a: assert property (manual_toggle |=> cmd.start)
        else $error("toggle did not start a regeneration");
    held_no_start_a: assert property ($stable(cmd_byte[0]) [*2] |=> !cmd.start)
        else $error("regeneration started without a toggle");
    pending_set_a: assert property (cmd.start && !clear_pending |=> cmd.pending)
        else $error("start did not leave a pending flag");

endmodule

// File: logic/sfp_frame_packer.sv
// Top level: register file on classic Wishbone and the 62-byte input image of the fieldbus slave.
`timescale 1ns/100ps
module sfp_frame_packer
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic                        wb_ack_o,
    output logic [31:0]                 wb_dat_o,
    input  wire logic [5:0]             img_addr,
    output logic [7:0]                  img_data,
    input  wire logic [7:0]             cmd_byte,
    output logic                        regen_start,
    output logic                        regen_lock,
    input  wire logic [3:0]             addr_switch_hi,
    input  wire logic [3:0]             addr_switch_lo,
    output logic [7:0]                  slave_addr,
    output logic                        slave_addr_ok
);

    typedef struct packed {
        logic [15:0]       fault;
        logic [15:0]       state;
        logic [15:0]       hours;
        logic [15:0]       days;
        logic [23:0]       cap;
        logic [3:0][31:0]  flow;
        logic [31:0]       regcnt;
        logic [31:0]       volume;
        logic              link_ok;
        logic              ack;
        logic [31:0]       rdat;
        logic [7:0]        img;
        logic [7:0]        addr;
        logic              addr_ok;
    } sfp_state_t;

    sfp_state_t            q;
    sfp_state_t            next_q;
    sfp_pkg::sfp_wb_req_t  req;
    sfp_pkg::sfp_cmd_t     cmd;
    logic                  wr_hit;
    logic                  clear_pending;

    // One driver for the whole carrier keeps each bit singly driven.
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                res[8*b +: 8] = nw[8*b +: 8];
        end
        return res;
    endfunction

    // Byte k of a word, counted from the most significant end.
    function automatic logic [7:0] msb_byte(input logic [31:0] w, input logic [1:0] k);
        return w[31 - 8*k -: 8];
    endfunction

    function automatic logic [7:0] image_byte(input sfp_state_t s, input logic [5:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx == 6'h00)
        begin
            b = {s.fault[sfp_pkg::F_FLOW1], s.fault[sfp_pkg::F_SIX_SEVEN],
                 s.fault[sfp_pkg::F_LOW], s.fault[sfp_pkg::F_HIGH],
                 s.fault[sfp_pkg::F_THREE], s.fault[sfp_pkg::F_TWO],
                 s.fault[sfp_pkg::F_ONE], s.fault[sfp_pkg::F_ZERO]};
        end
        else if (idx == 6'h01)
        begin
            b = {s.fault[sfp_pkg::F_MAINT], 1'b0, s.fault[sfp_pkg::F_CELL_D], s.fault[sfp_pkg::F_CELL_C],
                 s.fault[sfp_pkg::F_FLOW3], s.fault[sfp_pkg::F_B1_2],
                 s.fault[sfp_pkg::F_NINE], s.fault[sfp_pkg::F_FLOW2]};
        end
        else if (idx == 6'h02)
        begin
            b = {4'h0, s.state[sfp_pkg::S_REGEN], s.state[2:0]};
        end
        else if (idx == 6'h03)
        begin
            b = s.state[sfp_pkg::S_STEP_LSB +: 8];
        end
        else if (idx < sfp_pkg::IDX_CAP)
        begin
            // Hours then days, each high byte first.
            b = msb_byte({s.hours, s.days}, idx[1:0]);
        end
        else if (idx < sfp_pkg::IDX_FLOW1)
        begin
            b = s.cap[8*(idx - sfp_pkg::IDX_CAP) +: 8];
        end
        else if (idx < sfp_pkg::IDX_REGCNT)
        begin
            b = msb_byte(s.flow[2'((idx - sfp_pkg::IDX_FLOW1) >> 2)], 2'(idx - sfp_pkg::IDX_FLOW1));
        end
        else if (idx < sfp_pkg::IDX_VOLUME)
        begin
            b = msb_byte(s.regcnt, 2'(idx - sfp_pkg::IDX_REGCNT));
        end
        else if (idx < sfp_pkg::IDX_FREE)
        begin
            b = msb_byte(s.volume, 2'(idx - sfp_pkg::IDX_VOLUME));
        end
        else if (idx == sfp_pkg::IDX_LINK)
        begin
            b[sfp_pkg::B_LINK_OK] = s.link_ok;
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decoding.

    assign wr_hit        = req.cyc && req.stb && req.we && q.ack;
    assign clear_pending = wr_hit && (req.adr == sfp_pkg::ADR_CMD) && req.sel[0] && req.dat[sfp_pkg::C_PENDING];

    sfp_cmd_decode u_cmd
    (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .cmd_byte      (cmd_byte),
        .clear_pending (clear_pending),
        .cmd           (cmd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus slave, register file and image read port.
    // Writes land on the edge that the master samples ack, so a held write is
    // applied exactly once; the ack flop drops one cycle later by itself.

    always_comb
    begin
        logic [31:0] rd;
        rd     = 32'h0;
        next_q = q;
        next_q.ack = req.cyc && req.stb && !q.ack;
        if (wr_hit)
        begin
            case (req.adr)
                sfp_pkg::ADR_FAULT:  next_q.fault  = 16'(wb_merge({16'h0, q.fault}, req.dat, req.sel));
                sfp_pkg::ADR_STATE:  next_q.state  = 16'(wb_merge({16'h0, q.state}, req.dat, req.sel));
                sfp_pkg::ADR_HOURS:  next_q.hours  = 16'(wb_merge({16'h0, q.hours}, req.dat, req.sel));
                sfp_pkg::ADR_DAYS:   next_q.days   = 16'(wb_merge({16'h0, q.days}, req.dat, req.sel));
                sfp_pkg::ADR_CAP:    next_q.cap    = 24'(wb_merge({8'h0, q.cap}, req.dat, req.sel));
                sfp_pkg::ADR_FLOW1:  next_q.flow[0] = wb_merge(q.flow[0], req.dat, req.sel);
                sfp_pkg::ADR_FLOW2:  next_q.flow[1] = wb_merge(q.flow[1], req.dat, req.sel);
                sfp_pkg::ADR_FLOW3:  next_q.flow[2] = wb_merge(q.flow[2], req.dat, req.sel);
                sfp_pkg::ADR_BLEND:  next_q.flow[3] = wb_merge(q.flow[3], req.dat, req.sel);
                sfp_pkg::ADR_REGCNT: next_q.regcnt = wb_merge(q.regcnt, req.dat, req.sel);
                sfp_pkg::ADR_VOLUME: next_q.volume = wb_merge(q.volume, req.dat, req.sel);
                sfp_pkg::ADR_LINK:
                begin
                    if (req.sel[0])
                        next_q.link_ok = req.dat[0];
                end
                default:
                begin
                    next_q.link_ok = q.link_ok;
                end
            endcase
        end
        case (req.adr)
            sfp_pkg::ADR_FAULT:  rd = {16'h0, q.fault};
            sfp_pkg::ADR_STATE:  rd = {16'h0, q.state};
            sfp_pkg::ADR_HOURS:  rd = {16'h0, q.hours};
            sfp_pkg::ADR_DAYS:   rd = {16'h0, q.days};
            sfp_pkg::ADR_CAP:    rd = {8'h0, q.cap};
            sfp_pkg::ADR_FLOW1:  rd = q.flow[0];
            sfp_pkg::ADR_FLOW2:  rd = q.flow[1];
            sfp_pkg::ADR_FLOW3:  rd = q.flow[2];
            sfp_pkg::ADR_BLEND:  rd = q.flow[3];
            sfp_pkg::ADR_REGCNT: rd = q.regcnt;
            sfp_pkg::ADR_VOLUME: rd = q.volume;
            sfp_pkg::ADR_LINK:   rd = {31'h0, q.link_ok};
            sfp_pkg::ADR_CMD:
            begin
                rd[sfp_pkg::C_LOCK]              = cmd.lock;
                rd[sfp_pkg::C_PENDING]           = cmd.pending;
                rd[sfp_pkg::C_MANUAL]            = cmd_byte[sfp_pkg::CMD_MANUAL];
                rd[sfp_pkg::C_ADDR_LSB +: 8]     = q.addr;
                rd[sfp_pkg::C_ADDR_OK]           = q.addr_ok;
            end
            default:
            begin
                rd = 32'h0;
            end
        endcase
        if (next_q.ack && !req.we)
            next_q.rdat = rd;
        next_q.img = image_byte(q, img_addr);
        // The switches are read continuously; a new address only counts once the
        // engine restarts, which is outside this block.
        next_q.addr    = {addr_switch_hi, addr_switch_lo};
        next_q.addr_ok = (next_q.addr >= sfp_pkg::ADDR_MIN) && (next_q.addr <= sfp_pkg::ADDR_MAX);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign wb_ack_o      = q.ack;
    assign wb_dat_o      = q.rdat;
    assign img_data      = q.img;
    assign regen_start   = cmd.start;
    assign regen_lock    = cmd.lock;
    assign slave_addr    = q.addr;
    assign slave_addr_ok = q.addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence wb_new_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence img_at(logic [5:0] idx);
        img_addr == idx;
    endsequence

    ack_one_cycle_a: assert property (wb_new_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not one cycle after request");
    cell_current_a: assert property (img_at(6'h00) |=> img_data[5:4] == $past({q.fault[2], q.fault[1]}))
        else $error("cell current flags misplaced");
    flow_fault_a: assert property (img_at(6'h01) |=> img_data[0] == $past(q.fault[4]) && img_data[3] == $past(q.fault[5]))
        else $error("flow meter fault misplaced");
    in_service_a: assert property (img_at(6'h02) |=> img_data[3:0] == $past(q.state[3:0]) && img_data[7:4] == 4'h0)
        else $error("service flags misplaced");
    hours_msb_a: assert property (img_at(6'h04) |=> img_data == $past(q.hours[15:8]))
        else $error("hours high byte not first");
    days_lsb_a: assert property (img_at(6'h07) |=> img_data == $past(q.days[7:0]))
        else $error("days low byte misplaced");
    capacity_a: assert property (img_at(6'h0a) |=> img_data == $past(q.cap[23:16]))
        else $error("capacity three misplaced");
    blend_flow_a: assert property (img_at(6'h17) |=> img_data == $past(q.flow[3][31:24]))
        else $error("blend flow high byte misplaced");
    volume_last_a: assert property (img_at(6'h22) |=> img_data == $past(q.volume[7:0]))
        else $error("volume low byte misplaced");
    link_flag_a: assert property (img_at(6'h3d) |=> img_data == {$past(q.link_ok), 7'h00})
        else $error("link flag byte wrong");
    free_bytes_a: assert property (img_addr >= 6'h23 && img_addr != 6'h3d |=> img_data == 8'h00)
        else $error("free image byte not zero");
    addr_range_a: assert property (slave_addr_ok == (slave_addr >= 8'h01 && slave_addr <= 8'hfe))
        else $error("slave address out of range accepted");

endmodule

// File: verification/sfp_frame_packer_bench.sv
// Self-checking testbench for the softener status frame packer.
`timescale 1ns/100ps
module sfp_frame_packer_bench;

    logic        sys_clk;
    logic        rst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [5:0]  img_addr;
    logic [7:0]  img_data;
    logic [7:0]  cmd_byte;
    logic        regen_start;
    logic        regen_lock;
    logic [3:0]  addr_switch_hi;
    logic [3:0]  addr_switch_lo;
    logic [7:0]  slave_addr;
    logic        slave_addr_ok;
    int          n_errors;
    int          num_checks;
    int          cycles;
    int          n_starts;
    int          s0;
    logic [31:0] rd;
    int unsigned fld [5] = '{sfp_pkg::F_HIGH, sfp_pkg::F_LOW, sfp_pkg::F_FLOW1, sfp_pkg::F_FLOW2, sfp_pkg::F_FLOW3};
    logic [15:0] pos [5] = '{16'h0010, 16'h0020, 16'h0080, 16'h0100, 16'h0800};
    logic [7:0]  sw [5]  = '{8'h00, 8'h01, 8'hfe, 8'hff, 8'h7a};

    sfp_frame_packer uut
    (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .wb_cyc_i       (wb_cyc),
        .wb_stb_i       (wb_stb),
        .wb_we_i        (wb_we),
        .wb_adr_i       (wb_adr),
        .wb_sel_i       (wb_sel),
        .wb_dat_i       (wb_dat),
        .wb_ack_o       (wb_ack_o),
        .wb_dat_o       (wb_dat_o),
        .img_addr       (img_addr),
        .img_data       (img_data),
        .cmd_byte       (cmd_byte),
        .regen_start    (regen_start),
        .regen_lock     (regen_lock),
        .addr_switch_hi (addr_switch_hi),
        .addr_switch_lo (addr_switch_lo),
        .slave_addr     (slave_addr),
        .slave_addr_ok  (slave_addr_ok)
    );

    sfp_master_model master
    (
        .sys_clk  (sys_clk),
        .img_addr (img_addr),
        .img_data (img_data),
        .cmd_byte (cmd_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // The ceiling is dozens of times the expected run, so only a real hang reaches it.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (regen_start === 1'b1)
            n_starts++;
        if (cycles == 20000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize;
        if (n_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Classic single cycle; only the bench timeout ends a wait for a missing ack.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_sel <= 4'hf;
        wb_dat <= dat;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1);
        chk("wb_ack_wait", 32'(n), 32'd2);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    // Multi-byte fields are read back most significant byte first, except capacity, which comes low byte first.
    task automatic img(input logic [5:0] idx, input int n, input logic [31:0] val);
        logic [7:0] q;
        for (int k = 0; k < n; k++)
        begin
            master.read_img(idx + 6'(k), q);
            chk($sformatf("img_byte_%0d", idx + 6'(k)), {24'h0, q}, {24'h0, val[8 * (n - 1 - k) +: 8]});
        end
    endtask

    task automatic wr_img(input logic [7:0] adr, input logic [31:0] w, input logic [5:0] idx, input int n,
                          input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b1, adr, w, q);
        img(idx, n, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_errors = 0;
        num_checks = 0;
        cycles = 0;
        n_starts = 0;
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        addr_switch_hi = 4'h0;
        addr_switch_lo = 4'h0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 62; i++)
            img(6'(i), 1, 32'h0);
        for (int i = 0; i < 5; i++)
            wr_img(sfp_pkg::ADR_FAULT, 32'h1 << fld[i], 6'h00, 2, {16'h0, pos[i][7:0], pos[i][15:8]});
        wr_img(sfp_pkg::ADR_STATE, 32'h0000_00fd, 6'h02, 1, 32'h0d);
        wr_img(sfp_pkg::ADR_STATE, 32'h0000_0002, 6'h02, 1, 32'h02);
        wr_img(sfp_pkg::ADR_HOURS, 32'h5a5a_a5c3, sfp_pkg::IDX_HOURS, 2, 32'ha5c3);
        wr_img(sfp_pkg::ADR_DAYS, 32'h0000_1e2f, sfp_pkg::IDX_DAYS, 2, 32'h1e2f);
        wr_img(sfp_pkg::ADR_CAP, 32'h0033_2211, sfp_pkg::IDX_CAP, 3, 32'h0011_2233);
        wr_img(sfp_pkg::ADR_FLOW1, 32'h0001_e240, sfp_pkg::IDX_FLOW1, 4, 32'h0001_e240);
        wr_img(sfp_pkg::ADR_FLOW2, 32'h8a4b_0c1d, sfp_pkg::IDX_FLOW1 + 6'h04, 4, 32'h8a4b_0c1d);
        wr_img(sfp_pkg::ADR_FLOW3, 32'h1234_5678, sfp_pkg::IDX_FLOW1 + 6'h08, 4, 32'h1234_5678);
        wr_img(sfp_pkg::ADR_BLEND, 32'hfedc_ba98, sfp_pkg::IDX_FLOW1 + 6'h0c, 4, 32'hfedc_ba98);
        wr_img(sfp_pkg::ADR_VOLUME, 32'hc001_d00d, sfp_pkg::IDX_VOLUME, 4, 32'hc001_d00d);
        wr_img(sfp_pkg::ADR_LINK, 32'hffff_ffff, sfp_pkg::IDX_LINK, 1, 32'h80);
        for (int i = 35; i < 61; i++)
            img(6'(i), 1, 32'h0);
        wr_img(sfp_pkg::ADR_LINK, 32'h0000_0000, sfp_pkg::IDX_LINK, 1, 32'h00);
        wb(1'b0, sfp_pkg::ADR_HOURS, 32'h0, rd);
        chk("hours_reg", rd, 32'h0000_a5c3);
        wb(1'b0, 8'hfc, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // Starts are counted per cycle, so a stretched pulse shows as an extra start.
        s0 = n_starts;
        master.request_regen();
        repeat (6) @(posedge sys_clk);
        chk("starts_rise", 32'(n_starts - s0), 32'd1);
        // The pending flag stays up until software clears it with a one in bit 1.
        wb(1'b0, sfp_pkg::ADR_CMD, 32'h0, rd);
        chk("cmd_pending", rd, 32'h0000_0006);
        wb(1'b1, sfp_pkg::ADR_CMD, 32'h0000_0002, rd);
        wb(1'b0, sfp_pkg::ADR_CMD, 32'h0, rd);
        chk("cmd_cleared", rd, 32'h0000_0004);
        repeat (6) @(posedge sys_clk);
        chk("starts_held", 32'(n_starts - s0), 32'd1);
        master.request_regen();
        repeat (6) @(posedge sys_clk);
        chk("starts_fall", 32'(n_starts - s0), 32'd2);
        master.set_lock(1'b1);
        repeat (3) @(posedge sys_clk);
        chk("lock_on", {31'h0, regen_lock}, 32'h1);
        repeat (6) @(posedge sys_clk);
        chk("lock_held", {31'h0, regen_lock}, 32'h1);
        chk("lock_no_start", 32'(n_starts - s0), 32'd2);
        master.set_lock(1'b0);
        repeat (3) @(posedge sys_clk);
        chk("lock_off", {31'h0, regen_lock}, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge sys_clk);
            addr_switch_hi <= sw[i][7:4];
            addr_switch_lo <= sw[i][3:0];
            repeat (3) @(posedge sys_clk);
            chk("slave_addr", {24'h0, slave_addr}, {24'h0, sw[i]});
            chk("slave_addr_ok", {31'h0, slave_addr_ok}, {31'h0, sw[i] >= 8'h01 && sw[i] <= 8'hfe});
        end
        // A second reset in mid-run must clear what the first run loaded.
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        img(sfp_pkg::IDX_HOURS, 2, 32'h0);
        summarize();
    end

endmodule

// File: verification/sfp_master_model.sv
// Behavioural fieldbus master: fetches image bytes and drives the command byte.
`timescale 1ns/100ps
module sfp_master_model
(
    input  wire logic       sys_clk,
    output logic      [5:0] img_addr,
    input  wire logic [7:0] img_data,
    output logic      [7:0] cmd_byte
);

    initial
    begin
        img_addr = 6'h00;
        cmd_byte = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The byte is taken a full edge after the index, at the falling edge, so it has settled.
    task automatic read_img(input logic [5:0] idx, output logic [7:0] q);
        @(posedge sys_clk);
        img_addr <= idx;
        @(posedge sys_clk);
        @(negedge sys_clk);
        q = img_data;
    endtask

    // A regeneration request is a flip of bit 0, never a held level.
    task automatic request_regen;
        @(posedge sys_clk);
        cmd_byte[sfp_pkg::CMD_MANUAL] <= ~cmd_byte[sfp_pkg::CMD_MANUAL];
    endtask

    // The lock bit stays where it is put for as long as the lock is wanted.
    task automatic set_lock(input logic on);
        @(posedge sys_clk);
        cmd_byte[sfp_pkg::CMD_LOCK] <= on;
    endtask

endmodule
